// ===== pkg/vsi_cfg.svh
// Constants of the video input port: pixel word layout, mode codes, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef VSI_CFG_SVH
`define VSI_CFG_SVH

`define VSI_COLOR_W 8
`define VSI_WORD_W 27
`define VSI_DE_BIT 0
`define VSI_HS_BIT 1
`define VSI_VS_BIT 2
`define VSI_BLUE_LSB 3
`define VSI_GREEN_LSB 11
`define VSI_RED_LSB 19
`define VSI_CTL_W 3
`define VSI_FILT_N 2

`define VSI_MODE_FILT_OFF 2'h0
`define VSI_MODE_FILT_ON 2'h1
`define VSI_MODE_LEGACY_A 2'h2
`define VSI_MODE_LEGACY_B 2'h3

`define VSI_FILT_MIN_PCLK 3
`define VSI_FILT_CNT_W 2
`define VSI_PIPE_DEPTH 3

`define VSI_RST_MODE 2'h0
`define VSI_RST_LATCH 1'h0
`define VSI_RST_SELFTEST 1'h0
`define VSI_SER_IDLE_P 1'h1
`define VSI_SER_IDLE_N 1'h0

`endif

// ===== pkg/vsi_pkg.sv
// Types shared by the video input port and its buffer.
// Assumes the constant header is on the include path.
`include "vsi_cfg.svh"

package vsi_pkg;
  typedef logic [`VSI_WORD_W-1:0] word_t;
  typedef logic [1:0] mode_t;
  typedef enum logic [1:0] {
    PWR_OFF = 2'h1,
    PWR_ON = 2'h2
  } pwr_e;
  typedef enum logic [3:0] {
    FMT_CURRENT = 4'h1,
    FMT_CURRENT_FILT = 4'h2,
    FMT_LEGACY_A = 4'h4,
    FMT_LEGACY_B = 4'h8
  } link_fmt_e;
endpackage : vsi_pkg

// ===== hw/word_buffer.sv
// Two-entry buffer for captured pixel words, registered head output.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps

module word_buffer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire vsi_pkg::word_t inData,
  output logic outValid,
  input wire logic outReady,
  output vsi_pkg::word_t outData
);
  import vsi_pkg::*;

  word_t spare_ff;
  logic spareValid_ff;
  logic headValid_ff;
  word_t head_ff;
  wire logic push;
  wire logic pop;
  wire logic headFree;

  assign inReady = ~spareValid_ff;
  assign outValid = headValid_ff;
  assign outData = head_ff;
  assign push = inValid & ~spareValid_ff;
  assign pop = headValid_ff & outReady;
  assign headFree = ~headValid_ff | pop;

  ////////////////////////////////////////////////////////////////////////////
  // Spare slot absorbs one word while the head is stalled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      headValid_ff <= 1'h0;
      spareValid_ff <= 1'h0;
    end else begin
      if (headFree) begin
        headValid_ff <= spareValid_ff | push;
        spareValid_ff <= spareValid_ff & push;
      end else if (push) begin
        spareValid_ff <= 1'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      head_ff <= '0;
      spare_ff <= '0;
    end else begin
      if (headFree) begin
        head_ff <= spareValid_ff ? spare_ff : inData;
      end
      if (push && (spareValid_ff || !headFree)) begin
        spare_ff <= inData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_buf_stall_hold: assert property (@(posedge sys_clk) disable iff (rst)
    outValid && !outReady |=> outValid && $stable(outData))
    else $error("buffer head changed while stalled");
endmodule : word_buffer

// ===== hw/video_input_port.sv
// Parallel video input port: pixel capture on a chosen edge, control
// filter, clock crossing into sys_clk and a two-entry word buffer.
// Assumes sys_clk runs well above four times the pixel clock, and that
// configuration pins move only while video is idle.
`timescale 1ns/10ps
`include "vsi_cfg.svh"

module video_input_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pixClk,
  input wire logic [7:0] redIn,
  input wire logic [7:0] greenIn,
  input wire logic [7:0] blueIn,
  input wire logic pixelValidIn,
  input wire logic lineSyncIn,
  input wire logic frameSyncIn,
  input wire logic latchEdgeSelect,
  input wire vsi_pkg::mode_t opMode,
  input wire logic selfTestEnable,
  input wire logic powerDownN,
  output vsi_pkg::word_t wordOut,
  output logic wordValid,
  input wire logic wordReady,
  output logic wordDropped,
  output vsi_pkg::link_fmt_e linkFormat,
  output logic selfTestOn,
  output logic pllEnable,
  output logic serialOutP,
  output logic serialOutN
);
  import vsi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // System domain: pin synchronisers and control registers
  logic [4:0] cfgSync1_ff;
  logic [4:0] cfgSync2_ff;
  wire logic [4:0] cfgPins;
  wire logic pdnSync;
  wire logic latchSync;
  wire mode_t modeSync;
  wire logic selfTestSync;
  pwr_e pwrState_ff;
  pwr_e nxt_pwrState;
  mode_t mode_ff;
  logic latch_ff;
  logic selfTest_ff;
  logic pixRstReq_ff;
  link_fmt_e linkFormat_ff;
  link_fmt_e fmtDecode;
  logic pllEnable_ff;
  logic serialP_ff;
  logic serialN_ff;
  logic wordDropped_ff;
  wire logic poweredUp;

  assign cfgPins = {powerDownN, selfTestEnable, opMode, latchEdgeSelect};
  assign pdnSync = cfgSync2_ff[4];
  assign selfTestSync = cfgSync2_ff[3];
  assign modeSync = cfgSync2_ff[2:1];
  assign latchSync = cfgSync2_ff[0];
  assign poweredUp = (pwrState_ff == PWR_ON);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfgSync1_ff <= 5'h00;
      cfgSync2_ff <= 5'h00;
    end else begin
      cfgSync1_ff <= cfgPins;
      cfgSync2_ff <= cfgSync1_ff;
    end
  end

  always_comb begin
    case (pwrState_ff)
      PWR_OFF: nxt_pwrState = pdnSync ? PWR_ON : PWR_OFF;
      PWR_ON: nxt_pwrState = pdnSync ? PWR_ON : PWR_OFF;
      default: nxt_pwrState = PWR_OFF;
    endcase
  end

  always_comb begin
    case (mode_ff)
      `VSI_MODE_FILT_OFF: fmtDecode = FMT_CURRENT;
      `VSI_MODE_FILT_ON: fmtDecode = FMT_CURRENT_FILT;
      `VSI_MODE_LEGACY_A: fmtDecode = FMT_LEGACY_A;
      `VSI_MODE_LEGACY_B: fmtDecode = FMT_LEGACY_B;
      default: fmtDecode = FMT_CURRENT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwrState_ff <= PWR_OFF;
    end else begin
      pwrState_ff <= nxt_pwrState;
    end
  end

  // Control registers follow the pins only while powered
  always_ff @(posedge sys_clk) begin
    if (rst || !poweredUp) begin
      mode_ff <= `VSI_RST_MODE;
      latch_ff <= `VSI_RST_LATCH;
      selfTest_ff <= `VSI_RST_SELFTEST;
    end else begin
      mode_ff <= modeSync;
      latch_ff <= latchSync;
      selfTest_ff <= selfTestSync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !poweredUp) begin
      pllEnable_ff <= 1'h0;
      serialP_ff <= 1'h1;
      serialN_ff <= 1'h1;
      linkFormat_ff <= FMT_CURRENT;
      pixRstReq_ff <= 1'h1;
    end else begin
      pllEnable_ff <= 1'h1;
      serialP_ff <= `VSI_SER_IDLE_P;
      serialN_ff <= `VSI_SER_IDLE_N;
      linkFormat_ff <= fmtDecode;
      pixRstReq_ff <= 1'h0;
    end
  end

  assign linkFormat = linkFormat_ff;
  assign selfTestOn = selfTest_ff;
  assign pllEnable = pllEnable_ff;
  assign serialOutP = serialP_ff;
  assign serialOutN = serialN_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pixel domain: reset and settings crossed in by two flip-flops each
  logic pixRst1_ff;
  logic pixRst2_ff;
  logic [2:0] pixCfg1_ff;
  logic [2:0] pixCfg2_ff;
  wire logic latchPix;
  wire logic filterOn;
  wire word_t pinWord;
  word_t capR_ff;
  word_t capF_ff;
  word_t capWord_ff;
  word_t pipe_ff [`VSI_PIPE_DEPTH];
  logic [`VSI_FILT_N-1:0] filt_ff;
  word_t pixWord;
  word_t holdWord_ff;
  logic holdTgl_ff;

  // Mode bits only change while video is idle, so two-bit skew is harmless
  always_ff @(posedge pixClk) begin
    pixRst1_ff <= pixRstReq_ff;
    pixRst2_ff <= pixRst1_ff;
    pixCfg1_ff <= {mode_ff, latch_ff};
    pixCfg2_ff <= pixCfg1_ff;
  end

  assign latchPix = pixCfg2_ff[0];
  assign filterOn = (pixCfg2_ff[2:1] == `VSI_MODE_FILT_ON);
  assign pinWord = {redIn, greenIn, blueIn, frameSyncIn, lineSyncIn, pixelValidIn};

  // Both edges sample the whole word; the selected one is kept
  always_ff @(posedge pixClk) begin
    capR_ff <= pinWord;
  end

  always_ff @(negedge pixClk) begin
    capF_ff <= pinWord;
  end

  always_ff @(posedge pixClk) begin
    if (pixRst2_ff) begin
      capWord_ff <= '0;
    end else begin
      capWord_ff <= latchPix ? capR_ff : capF_ff;
    end
  end

  // Delay line keeps colour aligned with the filtered controls
  always_ff @(posedge pixClk) begin
    if (pixRst2_ff) begin
      for (int i = 0; i < `VSI_PIPE_DEPTH; i++) begin
        pipe_ff[i] <= '0;
      end
    end else begin
      pipe_ff[0] <= capWord_ff;
      for (int i = 1; i < `VSI_PIPE_DEPTH; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end

  for (genvar g = 0; g < `VSI_FILT_N; g++) begin : gFilt
    logic [`VSI_FILT_CNT_W-1:0] cnt_ff;
    wire logic differs;
    wire logic settled;

    assign differs = (capWord_ff[g] != filt_ff[g]);
    assign settled = (cnt_ff == `VSI_FILT_CNT_W'(`VSI_FILT_MIN_PCLK - 1));

    always_ff @(posedge pixClk) begin
      if (pixRst2_ff || !differs) begin
        cnt_ff <= '0;
      end else if (settled) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end

    always_ff @(posedge pixClk) begin
      if (pixRst2_ff) begin
        filt_ff[g] <= 1'h0;
      end else if (differs && settled) begin
        filt_ff[g] <= capWord_ff[g];
      end
    end

    a_filter_min_width: assert property (@(posedge pixClk) disable iff (pixRst2_ff)
      filterOn && $past(filterOn) && $changed(filt_ff[g]) |->
        $past(capWord_ff[g], 1) == filt_ff[g] && $past(capWord_ff[g], 2) == filt_ff[g]
        && $past(capWord_ff[g], 3) == filt_ff[g])
      else $error("control forwarded before three stable pixel clocks");
  end

  always_comb begin
    pixWord = pipe_ff[`VSI_PIPE_DEPTH-1];
    if (filterOn) begin
      pixWord[`VSI_FILT_N-1:0] = filt_ff;
    end
  end

  // Word held a full pixel period while its toggle crosses over
  always_ff @(posedge pixClk) begin
    if (pixRst2_ff) begin
      holdWord_ff <= '0;
      holdTgl_ff <= 1'h0;
    end else begin
      holdWord_ff <= pixWord;
      holdTgl_ff <= ~holdTgl_ff;
    end
  end

  a_filter_off_pass: assert property (@(posedge pixClk) disable iff (pixRst2_ff)
    (!filterOn)[*5] |-> holdWord_ff[1:0] == $past(capWord_ff[1:0], 4))
    else $error("unfiltered control does not follow capture");

  a_edge_rising: assert property (@(posedge pixClk) disable iff (pixRst2_ff)
    latchPix && $past(latchPix) && !$past(pixRst2_ff) && !$past(pixRst2_ff, 2)
      |-> capWord_ff == $past(pinWord, 2))
    else $error("rising-edge capture mismatch");

  a_edge_falling: assert property (@(posedge pixClk) disable iff (pixRst2_ff)
    !latchPix && !$past(latchPix) && !$past(pixRst2_ff) |-> capWord_ff == $past(capF_ff))
    else $error("falling-edge capture not selected");

  ////////////////////////////////////////////////////////////////////////////
  // System domain: toggle event capture into the buffer
  logic tglSync1_ff;
  logic tglSync2_ff;
  logic tglSync3_ff;
  wire logic wordEvent;
  wire logic bufInReady;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tglSync1_ff <= 1'h0;
      tglSync2_ff <= 1'h0;
      tglSync3_ff <= 1'h0;
    end else begin
      tglSync1_ff <= holdTgl_ff;
      tglSync2_ff <= tglSync1_ff;
      tglSync3_ff <= tglSync2_ff;
    end
  end

  assign wordEvent = (tglSync2_ff ^ tglSync3_ff) & poweredUp;

  // Video cannot be stalled; a word that meets a full buffer is flagged
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wordDropped_ff <= 1'h0;
    end else begin
      wordDropped_ff <= wordEvent & ~bufInReady;
    end
  end

  assign wordDropped = wordDropped_ff;

  word_buffer uBuffer (
    .sys_clk(sys_clk),
    .rst(rst || !poweredUp),
    .inValid(wordEvent),
    .inReady(bufInReady),
    .inData(holdWord_ff),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(wordOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  sequence s_pd_seen;
    !pdnSync ##1 !poweredUp;
  endsequence

  sequence s_pd_settled;
    !poweredUp ##1 !poweredUp;
  endsequence

  a_pd_outputs_high: assert property (@(posedge sys_clk) disable iff (rst)
    s_pd_seen |=> serialOutP && serialOutN && !pllEnable)
    else $error("power-down did not park serial outputs high");

  a_pd_regs_reset: assert property (@(posedge sys_clk) disable iff (rst)
    s_pd_settled |-> mode_ff == `VSI_RST_MODE && !selfTestOn && latch_ff == `VSI_RST_LATCH)
    else $error("control registers not held at reset while powered down");

  a_self_test_follow: assert property (@(posedge sys_clk) disable iff (rst)
    poweredUp && $past(poweredUp) |-> selfTestOn == $past(selfTestSync))
    else $error("self-test does not follow its input");

  a_mode_format: assert property (@(posedge sys_clk) disable iff (rst)
    poweredUp && $past(poweredUp) && $stable(mode_ff) |->
      (mode_ff == `VSI_MODE_LEGACY_A) == (linkFormat == FMT_LEGACY_A)
      && (mode_ff == `VSI_MODE_LEGACY_B) == (linkFormat == FMT_LEGACY_B)
      && (mode_ff == `VSI_MODE_FILT_ON) == (linkFormat == FMT_CURRENT_FILT))
    else $error("link format does not match mode");
endmodule : video_input_port

// ===== tb/video_source.sv
// Video source model: drives colour and control pins from pixClk.
// Assumes the bench runs pixClk and changes latchEdgeSelect only while idle.
`timescale 1ns/10ps

module video_source (
  input wire logic pixClk,
  input wire logic latchEdgeSelect,
  output logic [7:0] redIn,
  output logic [7:0] greenIn,
  output logic [7:0] blueIn,
  output logic pixelValidIn,
  output logic lineSyncIn,
  output logic frameSyncIn
);
  import vsi_pkg::*;
  word_t cur = '0;
  initial {redIn, greenIn, blueIn, frameSyncIn, lineSyncIn, pixelValidIn} = '0;
  ////////////////////////////////////////
  // Launch on the edge opposite capture
  // Colour inverted after capture: hold time over, a wrong edge reads garbage
  always @(pixClk) begin
    if (pixClk !== latchEdgeSelect) begin
      {redIn, greenIn, blueIn, frameSyncIn, lineSyncIn, pixelValidIn} <= cur;
    end else begin
      {redIn, greenIn, blueIn} <= ~{redIn, greenIn, blueIn};
    end
  end
  // One word per pixel clock; callers space control toggles
  task automatic put(input word_t w, input int n);
    repeat (n) begin
      do @(pixClk); while (pixClk !== latchEdgeSelect);
      cur = w;
    end
  endtask : put
endmodule : video_source

// ===== tb/video_input_port_bench.sv
// Bench for the video input port: reset, modes, capture, filter, power-down, stall.
// Assumes the design package and the source model are compiled first.
`timescale 1ns/10ps

module video_input_port_bench;
  import vsi_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic pixClk = 1'b0;
  logic latchEdgeSelect = 1'b1;
  mode_t opMode = 2'h0;
  logic selfTestEnable = 1'b0;
  logic powerDownN = 1'b1;
  logic wordReady = 1'b1;
  logic [7:0] redIn, greenIn, blueIn;
  logic pixelValidIn, lineSyncIn, frameSyncIn;
  word_t wordOut;
  logic wordValid, wordDropped, selfTestOn, pllEnable, serialOutP, serialOutN;
  link_fmt_e linkFormat;
  word_t got[$];
  int errorCnt = 0;
  int checkCount = 0;
  int droppedSeen = 0;

  initial forever #2.5 sys_clk = ~sys_clk;
  initial begin
    #3.7;
    forever #16 pixClk = ~pixClk;
  end

  video_source src (.pixClk(pixClk), .latchEdgeSelect(latchEdgeSelect), .redIn(redIn),
    .greenIn(greenIn), .blueIn(blueIn), .pixelValidIn(pixelValidIn),
    .lineSyncIn(lineSyncIn), .frameSyncIn(frameSyncIn));

  video_input_port uut (.sys_clk(sys_clk), .rst(rst), .pixClk(pixClk), .redIn(redIn),
    .greenIn(greenIn), .blueIn(blueIn), .pixelValidIn(pixelValidIn),
    .lineSyncIn(lineSyncIn), .frameSyncIn(frameSyncIn), .latchEdgeSelect(latchEdgeSelect),
    .opMode(opMode), .selfTestEnable(selfTestEnable), .powerDownN(powerDownN),
    .wordOut(wordOut), .wordValid(wordValid), .wordReady(wordReady),
    .wordDropped(wordDropped), .linkFormat(linkFormat), .selfTestOn(selfTestOn),
    .pllEnable(pllEnable), .serialOutP(serialOutP), .serialOutN(serialOutN));

  // Consumer side: every taken word is logged
  always @(posedge sys_clk) begin
    if (wordValid === 1'b1 && wordReady === 1'b1) got.push_back(wordOut);
    if (wordDropped === 1'b1) droppedSeen++;
  end
  ////////////////////////////////////////
  task automatic chk(input bit bad, input string m);
    checkCount++;
    if (bad) begin
      errorCnt++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic close_out;
    $display("Summary: %0d mismatches in %0d checks", errorCnt, checkCount);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // Pins are quasi-static, so settle time is generous
  task automatic cfg(input logic le, input mode_t m, input logic st, input logic pd);
    @(posedge sys_clk);
    latchEdgeSelect <= le;
    opMode <= m;
    selfTestEnable <= st;
    powerDownN <= pd;
    repeat (20) @(posedge sys_clk);
  endtask : cfg

  task automatic test_modes;
    link_fmt_e fmt[4] = '{FMT_CURRENT, FMT_CURRENT_FILT, FMT_LEGACY_A, FMT_LEGACY_B};
    for (int m = 0; m < 4; m++) begin
      cfg(1'b1, mode_t'(m), m[0], 1'b1);
      chk(linkFormat !== fmt[m], "link format");
      chk(selfTestOn !== m[0], "self test state");
    end
    $display("test_modes done");
  endtask : test_modes

  task automatic test_capture(input logic le);
    word_t w;
    word_t exp[$];
    int k = 0;
    cfg(le, 2'h0, 1'b0, 1'b1);
    src.put('0, 4);
    got.delete();
    for (int i = 0; i < 8; i++) begin
      w = {8'h01 << i, 8'h80 >> i, 8'h5A ^ 8'(i), 3'h1};
      exp.push_back(w);
      src.put(w, 1);
    end
    src.put('0, 140);
    foreach (got[j]) begin
      if (got[j][0] === 1'b1) begin
        chk(k >= 8 || got[j] !== exp[k], "captured word");
        k++;
      end
    end
    chk(k != 8, "captured word count");
    $display("test_capture edge %0b done", le);
  endtask : test_capture

  task automatic test_filter(input mode_t m, input int pos, input int width, input int want);
    int k = 0;
    cfg(1'b1, m, 1'b0, 1'b1);
    src.put('0, 4);
    got.delete();
    src.put((word_t'(1) << pos) | {8'hC3, 19'h0}, width);
    src.put('0, 140);
    foreach (got[j]) begin
      if (got[j][pos] === 1'b1) k++;
    end
    chk(k != want, "control pulse words");
    $display("test_filter mode %0d bit %0d width %0d done", m, pos, width);
  endtask : test_filter

  task automatic test_power;
    chk(pllEnable !== 1'b1 || serialOutP !== 1'b1 || serialOutN !== 1'b0, "powered");
    cfg(1'b1, 2'h3, 1'b1, 1'b1);
    cfg(1'b1, 2'h3, 1'b1, 1'b0);
    chk(pllEnable !== 1'b0 || serialOutP !== 1'b1 || serialOutN !== 1'b1, "down");
    chk(linkFormat !== FMT_CURRENT || selfTestOn !== 1'b0, "regs held");
    chk(wordValid !== 1'b0, "buffer flushed");
    cfg(1'b1, 2'h0, 1'b0, 1'b1);
    src.put('0, 10);
    chk(pllEnable !== 1'b1, "power back");
    $display("test_power done");
  endtask : test_power

  // Stall until words are refused, then drain until empty
  task automatic test_stall;
    int n = 0;
    droppedSeen = 0;
    @(posedge sys_clk) wordReady <= 1'b0;
    src.put('0, 12);
    chk(wordValid !== 1'b1 || droppedSeen == 0, "full buffer refuses");
    @(posedge sys_clk) wordReady <= 1'b1;
    while (wordValid !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    chk(wordValid !== 1'b0, "buffer drains");
    $display("test_stall done");
  endtask : test_stall
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    chk(wordValid !== 1'b0 || linkFormat !== FMT_CURRENT || selfTestOn !== 1'b0, "rst");
    chk(pllEnable !== 1'b0 || serialOutP !== 1'b1 || serialOutN !== 1'b1, "rst serial");
    rst <= 1'b0;
    repeat (50) @(posedge sys_clk);
    src.put('0, 10);
    test_power();
    test_modes();
    test_capture(1'b1);
    test_capture(1'b0);
    test_filter(2'h0, 0, 2, 2);
    test_filter(2'h0, 1, 1, 1);
    test_filter(2'h1, 0, 2, 0);
    test_filter(2'h1, 0, 3, 3);
    test_filter(2'h1, 1, 2, 0);
    test_filter(2'h1, 1, 3, 3);
    test_stall();
    close_out();
  end

  initial begin
    #200000;
    errorCnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
endmodule : video_input_port_bench
